// *** rtl/aesc_defs.svh ***
// Offsets, bit positions, masks and reset values of the error severity/control bank
`ifndef AESC_DEFS_SVH
`define AESC_DEFS_SVH
`define AESC_OFF_SEV 8'h0c
`define AESC_OFF_CSTAT 8'h10
`define AESC_OFF_CMASK 8'h14
`define AESC_OFF_CC 8'h18
`define AESC_OFF_HDR_LO 8'h1c
`define AESC_OFF_HDR_HI 8'h28
`define AESC_OFF_PFX_LO 8'h38
`define AESC_OFF_PFX_HI 8'h44
`define AESC_SEV_RST 32'h00462010
`define AESC_SEV_ALWAYS 32'h00155010
`define AESC_SEV_OPT 32'h03eaa000
`define AESC_UNC_VALID 32'h03fff010
`define AESC_CORR_BASE 32'h000031c1
`define AESC_CORR_OPT 32'h0000c000
`define AESC_CORR_RST 32'h00000000
`define AESC_CMASK_RST 32'h00000000
`define AESC_CC_PREFIX_LOG_PRESENT 11
`define AESC_CC_MULTI_HEADER_RECORD_ENABLE 10
`define AESC_CC_MULTI_HEADER_RECORD_CAPABLE 9
`define AESC_CC_ECE 8
`define AESC_CC_ECC 7
`define AESC_CC_EGE 6
`define AESC_CC_EGC 5
`define AESC_CORR_HLO 15
`define AESC_UNC_ECRC 19
`define AESC_RESP_OKAY 2'b00
`define AESC_RESP_SLVERR 2'b10
`endif

// *** rtl/aesc_pkg.sv ***
// Types and shared helper functions of the error severity/control bank
`include "aesc_defs.svh"
package aesc_pkg;
  // One register write from the bus front end
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } aesc_wr_req_t;
  // One batch of uncorrectable error events with the offending packet's header
  typedef struct packed {
    logic [31:0] evt;
    logic [127:0] hdr;
    logic [127:0] pfx;
    logic pfx_vld;
  } aesc_uerr_t;
  // Byte strobes widened to a bit mask
  function automatic logic [31:0] aesc_strb_mask(input logic [3:0] strb);
    aesc_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
  // Merge write data into an old value under byte strobes
  function automatic logic [31:0] aesc_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    aesc_merge = (old & ~aesc_strb_mask(strb)) | (data & aesc_strb_mask(strb));
  endfunction
  // True for every word address that holds a register or a log word
  function automatic logic aesc_is_mapped(input logic [7:0] addr);
    aesc_is_mapped = (addr[1:0] == 2'h0) &&
        ((addr >= `AESC_OFF_SEV && addr <= `AESC_OFF_HDR_HI) ||
         (addr >= `AESC_OFF_PFX_LO && addr <= `AESC_OFF_PFX_HI));
  endfunction
endpackage

// *** rtl/aesc_log_mem.sv ***
// Header and prefix log storage: two 128-bit rows, registered 32-bit read
module aesc_log_mem (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hdr_we,
  input wire logic [127:0] hdr_wdata,
  input wire logic [127:0] pfx_wdata,
  input wire logic [2:0] raddr,
  output logic [31:0] q_r
);
  logic [127:0] row_r [2]; // Row 0 header, row 1 prefix

  // Both rows are written together so a stale prefix never pairs with a new header
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      row_r[0] <= 128'h0;
      row_r[1] <= 128'h0;
    end else if (hdr_we) begin
      row_r[0] <= hdr_wdata;
      row_r[1] <= pfx_wdata;
    end
  end

  // Word 0 carries header bytes 0..3 with byte 0 in bits 31:24
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_r <= 32'h0;
    end else begin
      q_r <= row_r[raddr[2]][(3 - raddr[1:0]) * 32 +: 32];
    end
  end
endmodule // aesc_log_mem

// *** rtl/aesc_axil_slave.sv ***
// AXI4-Lite front end: one write and one read in flight, fixed answer timing
module aesc_axil_slave
  import aesc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output aesc_wr_req_t wr_req,
  output logic wr_fire,
  output logic [7:0] rd_addr_r,
  output logic rd_fire_r,
  input wire logic rd_ack,
  input wire logic [31:0] rd_data
);
  aesc_wr_req_t wr_hold_r; // Captured address, data and strobes

  // Fires once both halves are held and no response is pending
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_req = wr_hold_r;

  // Write channels: address and data are taken independently, in any order
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AESC_RESP_OKAY;
      wr_hold_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_hold_r.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_hold_r.data <= s_axi_wdata;
        wr_hold_r.strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aesc_is_mapped(wr_hold_r.addr) ? `AESC_RESP_OKAY : `AESC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // Reopen both channels only after the response is gone
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: request pulse, data one cycle later from the bank
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AESC_RESP_OKAY;
      rd_addr_r <= 8'h0;
      rd_fire_r <= 1'b0;
    end else begin
      rd_fire_r <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_addr_r <= s_axi_araddr;
      end
      if (rd_ack) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= aesc_is_mapped(rd_addr_r) ? `AESC_RESP_OKAY : `AESC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // aesc_axil_slave

// *** rtl/aesc_regs.sv ***
// Error severity, correctable status/mask and capability/control register bank
`include "aesc_defs.svh"

// Summary of operation
// - Severity bit one means fatal, zero non-fatal
// - Severity, status, mask untouched by hot reset
// - Severity resets one at bits 4,13,17,18,22
// - Always-writable severity bits; optional ones may be RO
// - Each correctable source has its own status bit
// - Correctable status is write-one-to-clear, resets zero
// - Optional status bits 14,15 read zero if absent
// - Masked correctable errors are not reported
// - Mask bits mirror status positions, reset zero
// - Prefix present reads one with valid pointer
// - Multi-header enable allows more than one header
// - Bit 9 reports multi-header recording capability
// - CRC check only while check enable set
// - Bit 7 reports CRC check capability
// - CRC generation only while generation enable set
// - Bit 5 reports CRC generation capability
// - Enables without mechanism are held at zero
// - First error pointer holds first error's bit; with multi-header enable set, each new capture overwrites it
// - Control fields untouched by hot reset
// - Masked uncorrectable errors are not logged or reported
// - Header log captures the failing packet header
module aesc_regs
  import aesc_pkg::*;
#(
  parameter logic [31:0] OPT_SEV_IMPL = `AESC_SEV_OPT, // Optional uncorrectable sources present
  parameter logic [31:0] OPT_CORR_IMPL = `AESC_CORR_OPT, // Optional correctable sources present
  parameter logic MULTI_HEADER_RECORD_CAPABLE_CAP = 1'b1, // Multi-header recording built in
  parameter logic ECC_CAP = 1'b1, // CRC checker built in
  parameter logic EGC_CAP = 1'b1 // CRC generator built in
) (
  // Clock and both resets
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hot_reset,
  // Write address and write data channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Uncorrectable events and the external mask/status
  input wire aesc_uerr_t uerr,
  input wire logic [31:0] uncorr_mask_in,
  input wire logic [31:0] uncorr_status_in,
  // Correctable pulses, one bit per source
  input wire logic [15:0] corr_err_evt,
  // One-cycle report pulses toward the host
  output logic fatal_report_r,
  output logic nonfatal_report_r,
  output logic corr_report_r,
  // Enable levels toward the packet datapath
  output logic crc_check_en_r,
  output logic crc_gen_en_r,
  output logic multi_header_en_r
);
  // Bits software may change, fixed at elaboration
  localparam logic [31:0] SEV_WR_MASK = `AESC_SEV_ALWAYS | (`AESC_SEV_OPT & OPT_SEV_IMPL);
  localparam logic [31:0] CORR_IMPL = `AESC_CORR_BASE | (`AESC_CORR_OPT & OPT_CORR_IMPL);

  // Lowest set bit of an error vector, the one taken as first
  function automatic logic [4:0] aesc_first_bit(input logic [31:0] v);
    aesc_first_bit = 5'h0;
    // Walk downward so the lowest set bit is written last
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        aesc_first_bit = 5'(i);
      end
    end
  endfunction

  // Front end strobes and read path
  aesc_wr_req_t wr_req; // Write from the front end
  logic wr_fire; // One-cycle write strobe
  logic [7:0] rd_addr_r; // Read address held by the front end
  logic rd_fire_r; // One-cycle read strobe
  logic rd_ack_r; // Read data ready for the front end
  logic rd_log_r; // Pending read targets the log memory
  logic [31:0] rd_reg_r; // Register read snapshot
  logic [31:0] mem_q_r; // Log memory read word
  logic [31:0] rd_data; // Word returned to the front end

  // Architectural state, sticky across hot reset
  logic [31:0] sev_r; // Uncorrectable severity
  logic [31:0] cstat_r; // Correctable status
  logic [31:0] cmask_r; // Correctable mask
  logic multi_header_record_enable_r; // Multi-header recording enable
  logic ece_r; // CRC check enable
  logic ege_r; // CRC generation enable
  logic [4:0] fep_r; // First error pointer
  logic log_vld_r; // Pointer and header log hold a live error
  logic pfx_vld_r; // Prefix log filled with the last capture

  // Event path, all combinational
  logic [31:0] unc_evt; // Uncorrectable events after the CRC gate
  logic [31:0] unc_live; // Unmasked uncorrectable events
  logic log_room; // A new header may be recorded
  logic capture; // Record header and pointer this cycle
  logic overflow; // Unmasked error lost for lack of room
  logic [31:0] corr_set; // Correctable status bits to set
  // Write decode and control word views
  logic [31:0] wbm; // Byte mask of the current write
  logic [31:0] cc_wr; // Control word after byte merge
  logic [31:0] cc_rd; // Control word as read
  logic wr_sev; // Write hits severity
  logic wr_cstat; // Write hits correctable status
  logic wr_cmask; // Write hits correctable mask
  logic wr_cc; // Write hits capability/control

  // Bus front end
  // It owns all handshake timing; the bank sees strobes only
  aesc_axil_slave u_slave (
    .ref_clk(ref_clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_fire(wr_fire),
    .rd_addr_r(rd_addr_r),
    .rd_fire_r(rd_fire_r),
    .rd_ack(rd_ack_r),
    .rd_data(rd_data)
  );

  // Header and prefix log; the prefix row is zero when none came with the packet
  aesc_log_mem u_log (
    .ref_clk(ref_clk),
    .reset(reset),
    .hdr_we(capture),
    .hdr_wdata(uerr.hdr),
    .pfx_wdata(uerr.pfx_vld ? uerr.pfx : 128'h0),
    // Word index within the log: header words 0..3, prefix words 4..7
    .raddr(rd_addr_r >= `AESC_OFF_PFX_LO ? {1'b1, 2'(rd_addr_r[3:2] - 2'h2)} :
        3'(rd_addr_r[4:2] - 3'h7)),
    .q_r(mem_q_r)
  );

  // Write decode; unmapped or misaligned writes hit nothing
  // Log words decode to nothing, so writes there are ignored
  assign wr_sev = wr_fire && (wr_req.addr == `AESC_OFF_SEV);
  assign wr_cstat = wr_fire && (wr_req.addr == `AESC_OFF_CSTAT);
  assign wr_cmask = wr_fire && (wr_req.addr == `AESC_OFF_CMASK);
  assign wr_cc = wr_fire && (wr_req.addr == `AESC_OFF_CC);
  // Strobes widened once, shared by the severity and status writes
  assign wbm = aesc_strb_mask(wr_req.strb);
  assign cc_wr = aesc_merge(cc_rd, wr_req.data, wr_req.strb);

  // CRC error events count only while checking is on
  always_comb begin
    // Reserved source bits are dropped here
    unc_evt = uerr.evt & `AESC_UNC_VALID;
    unc_evt[`AESC_UNC_ECRC] = uerr.evt[`AESC_UNC_ECRC] & ece_r;
  end

  // Masked sources are dropped before logging, pointer and report
  assign unc_live = unc_evt & ~uncorr_mask_in;
  // One header only unless multi-header recording is on
  assign log_room = !log_vld_r || multi_header_record_enable_r;
  // Capture and overflow never fire together
  assign capture = (|unc_live) && log_room;
  assign overflow = (|unc_live) && !log_room;

  // Correctable events, with lost headers counted as log overflow
  always_comb begin
    corr_set = {16'h0, corr_err_evt} & CORR_IMPL;
    // A lost header is itself a correctable event
    corr_set[`AESC_CORR_HLO] = (corr_err_evt[`AESC_CORR_HLO] | overflow) &
        CORR_IMPL[`AESC_CORR_HLO];
  end

  // Severity; optional sources not built stay at their reset value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Power-on values only
      sev_r <= `AESC_SEV_RST;
    end else if (wr_sev) begin
      // Only built and writable bits take new data
      sev_r <= (sev_r & ~(SEV_WR_MASK & wbm)) | (wr_req.data & SEV_WR_MASK & wbm);
    end
  end
  // Note: hot_reset deliberately reaches none of the sticky state.
  // Sticky state answers to the full reset alone

  // Correctable status; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cstat_r <= `AESC_CORR_RST;
    end else begin
      // Clear under the write's bytes, then set from events
      // Reserved and absent bits are forced to zero
      cstat_r <= ((cstat_r & ~(wr_cstat ? wr_req.data & wbm : 32'h0)) | corr_set) &
          CORR_IMPL;
    end
  end

  // Correctable mask, same layout as status
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmask_r <= `AESC_CMASK_RST;
    end else if (wr_cmask) begin
      // Absent sources keep their mask bit at zero
      cmask_r <= aesc_merge(cmask_r, wr_req.data, wr_req.strb) & CORR_IMPL;
    end
  end

  // Control enables; each is pinned low when its mechanism is absent
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Every mechanism starts disabled
      multi_header_record_enable_r <= 1'b0;
      ece_r <= 1'b0;
      ege_r <= 1'b0;
    end else if (wr_cc) begin
      // Merged word: unstrobed bytes keep their bits
      multi_header_record_enable_r <= cc_wr[`AESC_CC_MULTI_HEADER_RECORD_ENABLE] & MULTI_HEADER_RECORD_CAPABLE_CAP;
      ece_r <= cc_wr[`AESC_CC_ECE] & ECC_CAP;
      ege_r <= cc_wr[`AESC_CC_EGE] & EGC_CAP;
    end
  end

  // First error pointer and log ownership
  // The log is freed once software clears the pointed-to status bit;
  // a capture in the same cycle wins over that release.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Nothing logged after power-on
      fep_r <= 5'h0;
      log_vld_r <= 1'b0;
      pfx_vld_r <= 1'b0;
    end else if (capture) begin
      // Lowest unmasked source of this batch
      fep_r <= aesc_first_bit(unc_live);
      log_vld_r <= 1'b1;
      pfx_vld_r <= uerr.pfx_vld;
    end else if (log_vld_r && !uncorr_status_in[fep_r]) begin
      // Pointed-to status cleared: the log is free again
      log_vld_r <= 1'b0;
    end
  end

  // Control word as seen by software
  always_comb begin
    cc_rd = 32'h0;
    cc_rd[4:0] = fep_r;
    // Capability bits are constants of this build
    cc_rd[`AESC_CC_EGC] = EGC_CAP;
    cc_rd[`AESC_CC_EGE] = ege_r;
    cc_rd[`AESC_CC_ECC] = ECC_CAP;
    cc_rd[`AESC_CC_ECE] = ece_r;
    cc_rd[`AESC_CC_MULTI_HEADER_RECORD_CAPABLE] = MULTI_HEADER_RECORD_CAPABLE_CAP;
    cc_rd[`AESC_CC_MULTI_HEADER_RECORD_ENABLE] = multi_header_record_enable_r;
    // Prefix flag drops once the log is released
    cc_rd[`AESC_CC_PREFIX_LOG_PRESENT] = log_vld_r & pfx_vld_r;
  end

  // Error reports; hot reset drops a pulse in flight but keeps the registers
  always_ff @(posedge ref_clk) begin
    if (reset || hot_reset) begin
      // A pulse already in flight is simply lost
      fatal_report_r <= 1'b0;
      nonfatal_report_r <= 1'b0;
      corr_report_r <= 1'b0;
    end else begin
      // Both may pulse when a batch mixes severities
      fatal_report_r <= |(unc_live & sev_r);
      nonfatal_report_r <= |(unc_live & ~sev_r);
      // Masked bits still set status but raise no pulse
      corr_report_r <= |(corr_set & ~cmask_r);
    end
  end

  // Enables toward the packet datapath
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crc_check_en_r <= 1'b0;
      crc_gen_en_r <= 1'b0;
      multi_header_en_r <= 1'b0;
    end else begin
      // One stage keeps the datapath off bus timing
      crc_check_en_r <= ece_r;
      crc_gen_en_r <= ege_r;
      multi_header_en_r <= multi_header_record_enable_r;
    end
  end

  // Read snapshot one cycle after the request, same timing as the log memory
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // No read answer pending after reset
      rd_ack_r <= 1'b0;
      rd_log_r <= 1'b0;
      rd_reg_r <= 32'h0;
    end else begin
      // Register and log words are ready at the same edge
      rd_ack_r <= rd_fire_r;
      rd_log_r <= aesc_is_mapped(rd_addr_r) && (rd_addr_r >= `AESC_OFF_HDR_LO);
      // Unmapped addresses fall to the default, zero
      case (rd_addr_r)
        `AESC_OFF_SEV: rd_reg_r <= sev_r;
        `AESC_OFF_CSTAT: rd_reg_r <= cstat_r;
        `AESC_OFF_CMASK: rd_reg_r <= cmask_r;
        `AESC_OFF_CC: rd_reg_r <= cc_rd;
        default: rd_reg_r <= 32'h0;
      endcase
    end
  end

  // Log word or register snapshot
  assign rd_data = rd_log_r ? mem_q_r : rd_reg_r;
endmodule // aesc_regs

// *** test/aesc_regs_asserts.sv ***
// Port-level concurrent checks of the error severity/control register bank
module aesc_regs_chk
  import aesc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hot_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aesc_uerr_t uerr,
  input wire logic [31:0] uncorr_mask_in,
  input wire logic [15:0] corr_err_evt,
  input wire logic fatal_report_r,
  input wire logic nonfatal_report_r,
  input wire logic corr_report_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Unmasked uncorrectable events; masked ones must never cause a report
  logic [31:0] live_evt;
  assign live_evt = uerr.evt & ~uncorr_mask_in;
  // Both write halves taken at one edge, as the bench offers them
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_fatal_cause: assert property (fatal_report_r |-> $past(live_evt) != 32'h0)
    else $error("fatal report without unmasked event");
  a_nonfatal_cause: assert property (nonfatal_report_r |-> $past(live_evt) != 32'h0)
    else $error("non-fatal report without unmasked event");
  a_corr_cause: assert property (corr_report_r |->
      $past(corr_err_evt) != 16'h0 || $past(live_evt) != 32'h0)
    else $error("correctable report without any event");
  a_hot_quiet: assert property (hot_reset |=>
      !fatal_report_r && !nonfatal_report_r && !corr_report_r)
    else $error("report pulse survived hot reset");
  a_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not seen two edges after take");
  a_read_answer: assert property (rd_take |=> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not seen three edges after take");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write handshake did not close");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read handshake did not close");
  a_gap_read: assert property (rd_take and s_axi_araddr == 8'h30 |=>
      ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not zero with error");
endmodule // aesc_regs_chk

// *** test/aesc_regs_tb.sv ***
// Self-checking bench of the error severity/control register bank
module aesc_regs_tb
  import aesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1, hot_reset = 1'b0; // Clock and both resets
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0; // Write data
  logic [3:0] s_axi_wstrb = 4'h0; // Byte enables
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  aesc_uerr_t uerr = '0; // Uncorrectable event batch
  logic [31:0] uncorr_mask_in = 32'h0, uncorr_status_in = 32'h0;
  logic [15:0] corr_err_evt = 16'h0; // Correctable event pulses
  logic fatal_report_r, nonfatal_report_r, corr_report_r;
  logic crc_check_en_r, crc_gen_en_r, multi_header_en_r;
  int err_total = 0, tests_run = 0; // Mismatch and comparison counts

  aesc_regs dut (.ref_clk, .reset, .hot_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .uerr, .uncorr_mask_in, .uncorr_status_in, .corr_err_evt,
    .fatal_report_r, .nonfatal_report_r, .corr_report_r, .crc_check_en_r, .crc_gen_en_r,
    .multi_header_en_r);

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compare and count; a unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Full-word write; both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Read and compare data and response taken at the handshake edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // One-cycle event pulse, then the three report pulses one cycle later
  task automatic ev(input logic [31:0] ue, input logic [15:0] ce, input logic [2:0] rep);
    @(posedge ref_clk);
    uerr.evt <= ue;
    corr_err_evt <= ce;
    @(posedge ref_clk);
    uerr.evt <= 32'h0;
    corr_err_evt <= 16'h0;
    uncorr_status_in <= uncorr_status_in | ue;
    @(posedge ref_clk);
    chk({29'h0, fatal_report_r, nonfatal_report_r, corr_report_r}, {29'h0, rep});
  endtask

  // Counts, verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h0c, 32'h00462010, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    rd(8'h18, 32'h000002a0, 2'h0);
    wr(8'h0c, 32'hffffffff, 2'h0);
    rd(8'h0c, 32'h03fff010, 2'h0);
    wr(8'h0c, 32'h00000010, 2'h0);
    rd(8'h0c, 32'h00000010, 2'h0);
    ev(32'h0, 16'hffff, 3'b001);
    rd(8'h10, 32'h0000f1c1, 2'h0);
    wr(8'h10, 32'h00000001, 2'h0);
    rd(8'h10, 32'h0000f1c0, 2'h0);
    wr(8'h14, 32'hffffffff, 2'h0);
    rd(8'h14, 32'h0000f1c1, 2'h0);
    ev(32'h0, 16'h0001, 3'b000);
    rd(8'h10, 32'h0000f1c1, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h10, 32'hffffffff, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    // Control enables, and their copies one cycle behind the register
    wr(8'h18, 32'hffffffff, 2'h0);
    rd(8'h18, 32'h000007e0, 2'h0);
    repeat (2) @(posedge ref_clk);
    chk({29'h0, crc_check_en_r, crc_gen_en_r, multi_header_en_r}, 32'h7);
    wr(8'h18, 32'h0, 2'h0);
    rd(8'h18, 32'h000002a0, 2'h0);
    // First uncorrectable error with header and prefix
    uerr.hdr <= 128'h00112233_44556677_8899aabb_ccddeeff;
    uerr.pfx <= 128'h01020304_05060708_090a0b0c_0d0e0f10;
    uerr.pfx_vld <= 1'b1;
    ev(32'h00000010, 16'h0, 3'b100);
    rd(8'h18, 32'h00000aa4, 2'h0);
    rd(8'h1c, 32'h00112233, 2'h0);
    rd(8'h44, 32'h0d0e0f10, 2'h0);
    // Second error while one header is held: no room, overflow flagged
    ev(32'h00001000, 16'h0, 3'b011);
    rd(8'h18, 32'h00000aa4, 2'h0);
    rd(8'h10, 32'h00008000, 2'h0);
    uncorr_mask_in <= 32'h00004000;
    ev(32'h00004000, 16'h0, 3'b000);
    uncorr_status_in <= 32'h0;
    rd(8'h18, 32'h000002a4, 2'h0);
    // Hot reset keeps severity, correctable status and the control word
    @(posedge ref_clk);
    hot_reset <= 1'b1;
    @(posedge ref_clk);
    hot_reset <= 1'b0;
    rd(8'h0c, 32'h00000010, 2'h0);
    rd(8'h10, 32'h00008000, 2'h0);
    rd(8'h18, 32'h000002a4, 2'h0);
    // Unmapped places and the read-only log
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h00, 32'hffffffff, 2'h2);
    wr(8'h1c, 32'hffffffff, 2'h0);
    rd(8'h1c, 32'h00112233, 2'h0);
    test_done();
  end

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #50000;
    err_total++;
    test_done();
  end
endmodule // aesc_regs_tb

bind aesc_regs aesc_regs_chk u_chk (.ref_clk, .reset, .hot_reset, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .uerr, .uncorr_mask_in, .corr_err_evt, .fatal_report_r, .nonfatal_report_r, .corr_report_r);
